// [src/aq_cmd_ctrl.sv]
// Purpose: Mode and command controller of the air-quality module
// Assumes: A link front end decodes commands to cmd_t and serialises replies
// Notes:   CRC and byte framing live in the front end; words leave one per cycle
`timescale 1ns/1ps
`include "aq_cmd_defines.svh"

module aq_cmd_ctrl
	import aq_cmd_pkg::*;
#(
	parameter int STARTUP_CYCLES = `STARTUP_CYC,
	parameter int STORE_CYCLES   = `STORE_CYC,
	parameter int RESTART_CYCLES = `RESTART_CYC,
	parameter int SAMPLE_CYCLES  = `SAMPLE_CYC
) (
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic        sel_pin,
	input  wire logic        cmd_valid,
	input  wire cmd_t        cmd_code,
	input  wire logic [15:0] cmd_w0,
	input  wire logic [15:0] cmd_w1,
	input  wire logic [15:0] cmd_w2,
	input  wire logic [15:0] cmd_w3,
	input  wire logic [15:0] index_in,
	input  wire logic [15:0] raw_gas_signal,
	input  wire logic [15:0] hum_raw,
	input  wire logic [15:0] temp_raw,
	input  wire logic [63:0] algo_state_in,
	input  wire logic [15:0] nv_ofs,
	input  wire logic [63:0] nv_tune,
	output logic             ready_ff,
	output logic             measuring_ff,
	output logic             uart_mode_ff,
	output logic             ack_ff,
	output logic             err_ff,
	output logic             rsp_valid_ff,
	output logic [15:0]      rsp_word_ff,
	output logic             rsp_last_ff,
	output logic             sample_ff,
	output logic [15:0]      hum_comp_ff,
	output logic [15:0]      temp_comp_ff,
	output logic             nv_write_ff,
	output logic [15:0]      nv_ofs_out_ff,
	output logic [63:0]      nv_tune_out_ff,
	output logic             algo_load_ff,
	output logic [63:0]      algo_state_out_ff
);
	// Clamp a tuning word into its legal window
	function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
		clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	logic        sel_s1_ff, sel_s2_ff;
	mode_t       mode_ff, nxt_mode;
	logic [31:0] cnt_ff, nxt_cnt;
	logic [31:0] smp_ff, nxt_smp;
	logic [15:0] ofs_ff, nxt_ofs;
	logic [15:0] tune_ff [4];
	logic [15:0] nxt_tune [4];
	logic [63:0] algo_ff, nxt_algo;
	logic        algo_pend_ff, nxt_algo_pend;
	logic [15:0] rsp_buf_ff [6];
	logic [15:0] nxt_rsp_buf [6];
	logic [2:0]  rsp_idx_ff, nxt_rsp_idx;
	logic [2:0]  rsp_len_ff, nxt_rsp_len;
	logic        nxt_ack, nxt_err, nxt_sample, nxt_nv_write, nxt_algo_load, nxt_uart;
	logic        nxt_rsp_valid, nxt_rsp_last;
	logic [15:0] nxt_rsp_word, nxt_hum, nxt_temp;
	logic [15:0] nxt_nv_ofs_out;
	logic [63:0] nxt_nv_tune_out, nxt_algo_out;
	logic        accepted;

	// Select pin comes from outside; two flops before use
	always_ff @(posedge mclk) begin
		sel_s1_ff <= sel_pin;
		sel_s2_ff <= sel_s1_ff;
	end

	// Outside boot and restart a nonzero cnt_ff marks the persist busy time, so no extra state is needed
	assign accepted = cmd_valid && (mode_ff == st_idle || mode_ff == st_measure) && cnt_ff == 32'h0 &&
		rsp_len_ff == 3'h0;

	// Command, mode and parameter next-state logic
	always_comb begin
		nxt_mode        = mode_ff;
		nxt_cnt         = cnt_ff;
		nxt_smp         = smp_ff;
		nxt_ofs         = ofs_ff;
		nxt_tune        = tune_ff;
		nxt_algo        = algo_ff;
		nxt_algo_pend   = algo_pend_ff;
		nxt_rsp_buf     = rsp_buf_ff;
		nxt_rsp_idx     = rsp_idx_ff;
		nxt_rsp_len     = rsp_len_ff;
		nxt_ack         = 1'b0;
		nxt_err         = 1'b0;
		nxt_sample      = 1'b0;
		nxt_nv_write    = 1'b0;
		nxt_algo_load   = 1'b0;
		nxt_uart        = uart_mode_ff;
		nxt_hum         = hum_comp_ff;
		nxt_temp        = temp_comp_ff;
		nxt_nv_ofs_out  = nv_ofs_out_ff;
		nxt_nv_tune_out = nv_tune_out_ff;
		nxt_algo_out    = algo_state_out_ff;
		nxt_rsp_valid   = 1'b0;
		nxt_rsp_last    = 1'b0;
		nxt_rsp_word    = rsp_word_ff;
		// Reply words leave one per cycle from the buffer
		if (rsp_len_ff != 3'h0) begin
			nxt_rsp_valid = 1'b1;
			nxt_rsp_word  = rsp_buf_ff[rsp_idx_ff];
			nxt_rsp_last  = (rsp_idx_ff + 3'h1) == rsp_len_ff;
			nxt_rsp_idx   = rsp_idx_ff + 3'h1;
			if (nxt_rsp_last) begin
				nxt_rsp_len = 3'h0;
				nxt_rsp_idx = 3'h0;
			end
		end
		case (mode_ff)
			st_boot, st_restart: begin
				// Boot latency kept short so the 100 ms limit holds with margin
				nxt_cnt = cnt_ff + 32'h1;
				if (cnt_ff == 32'h0) begin
					nxt_ofs     = nv_ofs;
					nxt_tune[0] = clamp(nv_tune[15:0], `TGT_MIN, `TGT_MAX);
					nxt_tune[1] = clamp(nv_tune[31:16], `LRN_MIN, `LRN_MAX);
					nxt_tune[2] = clamp(nv_tune[47:32], 16'h0000, `GATE_MAX);
					nxt_tune[3] = clamp(nv_tune[63:48], `SDEV_MIN, `SDEV_MAX);
					nxt_algo_pend = 1'b0;
					nxt_uart = sel_s2_ff;
				end
				if (cnt_ff >= `BOOT_LAST) begin
					nxt_mode = st_idle;
					nxt_cnt  = 32'h0;
				end
			end
			st_measure: begin
				// Sampling runs off its own counter, never off reads
				nxt_smp = smp_ff + 32'h1;
				if (smp_ff >= 32'(SAMPLE_CYCLES - 1)) begin
					nxt_smp    = 32'h0;
					nxt_sample = 1'b1;
					nxt_hum    = hum_raw;
					nxt_temp   = temp_raw - ofs_ff;
				end
			end
			default: ;
		endcase
		// Persist busy time runs beside the mode, so measuring and sampling carry on
		if ((mode_ff == st_idle || mode_ff == st_measure) && cnt_ff != 32'h0) begin
			nxt_cnt = cnt_ff + 32'h1;
			if (cnt_ff >= 32'(STORE_CYCLES)) begin
				nxt_cnt = 32'h0;
			end
		end
		if (accepted) begin
			nxt_ack = 1'b1;
			case (cmd_code)
				cmd_begin_sampling: begin
					if (mode_ff == st_idle) begin
						nxt_mode = st_measure;
						nxt_smp  = 32'h0;
						if (algo_pend_ff) begin
							nxt_algo_load = 1'b1;
							nxt_algo_pend = 1'b0;
						end
					end
				end
				cmd_end_sampling: nxt_mode = st_idle;
				cmd_soft_restart: begin
					nxt_mode = st_restart;
					nxt_cnt  = 32'h0;
				end
				cmd_read_outputs, cmd_read_outputs_with_raw: begin
					nxt_rsp_buf[0] = index_in;
					nxt_rsp_buf[1] = hum_comp_ff;
					nxt_rsp_buf[2] = temp_comp_ff;
					nxt_rsp_buf[3] = raw_gas_signal;
					nxt_rsp_buf[4] = hum_raw;
					nxt_rsp_buf[5] = temp_raw;
					nxt_rsp_len = (cmd_code == cmd_read_outputs) ? `RSP_STD_WORDS : `RSP_RAW_WORDS;
				end
				cmd_read_temp_offset: begin
					nxt_rsp_buf[0] = ofs_ff;
					nxt_rsp_len    = 3'h1;
				end
				cmd_write_temp_offset: begin
					if (mode_ff == st_idle) nxt_ofs = cmd_w0;
					else nxt_err = 1'b1;
				end
				cmd_read_tuning, cmd_read_algo_state: begin
					for (int i = 0; i < 4; i++) begin
						nxt_rsp_buf[i] = (cmd_code == cmd_read_tuning) ? tune_ff[i] : algo_state_in[16*i +: 16];
					end
					nxt_rsp_len = `RSP_TUNE_WORDS;
				end
				cmd_write_tuning: begin
					nxt_tune[0] = clamp(cmd_w0, `TGT_MIN, `TGT_MAX);
					nxt_tune[1] = clamp(cmd_w1, `LRN_MIN, `LRN_MAX);
					nxt_tune[2] = clamp(cmd_w2, 16'h0000, `GATE_MAX);
					nxt_tune[3] = clamp(cmd_w3, `SDEV_MIN, `SDEV_MAX);
				end
				cmd_persist_settings: begin
					nxt_nv_write    = 1'b1;
					nxt_nv_ofs_out  = ofs_ff;
					nxt_nv_tune_out = {tune_ff[3], tune_ff[2], tune_ff[1], tune_ff[0]};
					nxt_cnt         = 32'h1;
				end
				cmd_write_algo_state: begin
					if (mode_ff == st_idle) begin
						nxt_algo = {cmd_w3, cmd_w2, cmd_w1, cmd_w0};
						nxt_algo_out  = {cmd_w3, cmd_w2, cmd_w1, cmd_w0};
						nxt_algo_pend = 1'b1;
					end else begin
						nxt_err = 1'b1;
					end
				end
				default: nxt_err = 1'b1;
			endcase
		end
	end

	// Registers; boot counts from zero on every reset
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			mode_ff      <= st_boot;
			cnt_ff       <= 32'h0;
			smp_ff       <= 32'h0;
			ofs_ff       <= `OFS_DEF;
			tune_ff[0]   <= `TGT_DEF;
			tune_ff[1]   <= `LRN_DEF;
			tune_ff[2]   <= `GATE_DEF;
			tune_ff[3]   <= `SDEV_DEF;
			algo_ff      <= 64'h0;
			algo_pend_ff <= 1'b0;
			for (int i = 0; i < 6; i++) rsp_buf_ff[i] <= 16'h0000;
			rsp_idx_ff   <= 3'h0;
			rsp_len_ff   <= 3'h0;
			ready_ff     <= 1'b0;
			measuring_ff <= 1'b0;
			uart_mode_ff <= 1'b1;
			ack_ff       <= 1'b0;
			err_ff       <= 1'b0;
			rsp_valid_ff <= 1'b0;
			rsp_word_ff  <= 16'h0000;
			rsp_last_ff  <= 1'b0;
			sample_ff    <= 1'b0;
			hum_comp_ff  <= 16'h0000;
			temp_comp_ff <= 16'h0000;
			nv_write_ff  <= 1'b0;
			nv_ofs_out_ff     <= 16'h0000;
			nv_tune_out_ff    <= 64'h0;
			algo_load_ff      <= 1'b0;
			algo_state_out_ff <= 64'h0;
		end else begin
			mode_ff      <= nxt_mode;
			cnt_ff       <= nxt_cnt;
			smp_ff       <= nxt_smp;
			ofs_ff       <= nxt_ofs;
			tune_ff      <= nxt_tune;
			algo_ff      <= nxt_algo;
			algo_pend_ff <= nxt_algo_pend;
			rsp_buf_ff   <= nxt_rsp_buf;
			rsp_idx_ff   <= nxt_rsp_idx;
			rsp_len_ff   <= nxt_rsp_len;
			ready_ff     <= ((nxt_mode == st_idle) || (nxt_mode == st_measure)) && nxt_cnt == 32'h0;
			measuring_ff <= nxt_mode == st_measure;
			uart_mode_ff <= nxt_uart;
			ack_ff       <= nxt_ack;
			err_ff       <= nxt_err;
			rsp_valid_ff <= nxt_rsp_valid;
			rsp_word_ff  <= nxt_rsp_word;
			rsp_last_ff  <= nxt_rsp_last;
			sample_ff    <= nxt_sample;
			hum_comp_ff  <= nxt_hum;
			temp_comp_ff <= nxt_temp;
			nv_write_ff  <= nxt_nv_write;
			nv_ofs_out_ff     <= nxt_nv_ofs_out;
			nv_tune_out_ff    <= nxt_nv_tune_out;
			algo_load_ff      <= nxt_algo_load;
			algo_state_out_ff <= nxt_algo_out;
		end
	end

	// Checks on the mode machine and data paths
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	sequence boot_seq;
		mode_ff == st_boot [*5];
	endsequence
	boot_ready_a: assert property (boot_seq |=> ready_ff) else $error("idle not reached after boot");
	measure_hold_a: assert property (measuring_ff && !(accepted && (cmd_code == cmd_end_sampling ||
		cmd_code == cmd_soft_restart)) |=> measuring_ff) else $error("measure mode left without cause");
	sample_rate_a: assert property (sample_ff |=> !sample_ff [*2]) else $error("samples too close");
	std_len_a: assert property (accepted && cmd_code == cmd_read_outputs |=> rsp_len_ff == 3'h3)
		else $error("wrong reply length");
	raw_len_a: assert property (accepted && cmd_code == cmd_read_outputs_with_raw |=> rsp_len_ff == 3'h6)
		else $error("wrong raw reply length");
	ofs_reply_a: assert property (accepted && cmd_code == cmd_read_temp_offset |=> ##1 rsp_valid_ff && rsp_last_ff)
		else $error("offset reply missing");
	comp_temp_a: assert property (sample_ff |-> temp_comp_ff == $past(temp_raw) - $past(ofs_ff))
		else $error("temperature not compensated");
	tune_range_a: assert property (tune_ff[0] >= `TGT_MIN && tune_ff[0] <= `TGT_MAX && tune_ff[3] >= `SDEV_MIN)
		else $error("tuning out of range");
	persist_a: assert property (accepted && cmd_code == cmd_persist_settings |=> nv_write_ff && !ready_ff)
		else $error("persist not started");
	refuse_a: assert property (accepted && measuring_ff && cmd_code == cmd_write_temp_offset |=> err_ff && $stable(ofs_ff))
		else $error("offset write not refused");
	restart_a: assert property (accepted && cmd_code == cmd_soft_restart |=> ack_ff ##[1:8] ready_ff)
		else $error("restart did not return to idle");
endmodule

// [src/aq_cmd_defines.svh]
// Purpose: Constants for the air-quality command controller
// Assumes: 100 MHz mclk
// Notes:   Times kept in their own units, cycle counts derived; BOOT_LAST is given in cycles
`ifndef AQ_CMD_DEFINES_SVH
`define AQ_CMD_DEFINES_SVH
`define CLK_MHZ          100
`define STARTUP_MS       100
`define STORE_MS         500
`define RESTART_MS       100
`define SAMPLE_S         1
`define STARTUP_CYC      (`STARTUP_MS * 1000 * `CLK_MHZ)
`define STORE_CYC        (`STORE_MS * 1000 * `CLK_MHZ)
`define RESTART_CYC      (`RESTART_MS * 1000 * `CLK_MHZ)
`define SAMPLE_CYC       (`SAMPLE_S * 1000000 * `CLK_MHZ)
`define BOOT_LAST        32'h00000003
`define TGT_DEF          16'h0064
`define TGT_MIN          16'h0001
`define TGT_MAX          16'h00fa
`define LRN_DEF          16'h000c
`define LRN_MIN          16'h0001
`define LRN_MAX          16'h0048
`define GATE_DEF         16'h00b4
`define GATE_MAX         16'h02d0
`define SDEV_DEF         16'h0032
`define SDEV_MIN         16'h000a
`define SDEV_MAX         16'h01f4
`define OFS_DEF          16'h0000
`define RSP_STD_WORDS    3'h3
`define RSP_RAW_WORDS    3'h6
`define RSP_TUNE_WORDS   3'h4
`endif

// [src/aq_cmd_pkg.sv]
// Purpose: Types for the air-quality command controller
// Assumes: Nothing beyond the defines header
// Notes:   Command codes are local encodings, not link codes
package aq_cmd_pkg;
	typedef enum logic [3:0] {
		cmd_none,
		cmd_begin_sampling,
		cmd_end_sampling,
		cmd_soft_restart,
		cmd_read_outputs,
		cmd_read_outputs_with_raw,
		cmd_read_temp_offset,
		cmd_write_temp_offset,
		cmd_read_tuning,
		cmd_write_tuning,
		cmd_persist_settings,
		cmd_read_algo_state,
		cmd_write_algo_state
	} cmd_t;
	typedef enum logic [2:0] {
		st_boot,
		st_idle,
		st_measure,
		st_store,
		st_restart
	} mode_t;
endpackage

// [bench/aq_host_model.sv]
// Purpose: Host master model sending decoded commands
// Assumes: Requests are taken while ready_ff is high and no reply is leaving
// Notes:   Flags and reply words are gathered per command
`timescale 1ns/1ps
module aq_host_model
	import aq_cmd_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        ready_ff,
	input  wire logic        ack_ff,
	input  wire logic        err_ff,
	input  wire logic        rsp_valid_ff,
	input  wire logic [15:0] rsp_word_ff,
	input  wire logic        rsp_last_ff,
	output logic             sel_pin,
	output logic             cmd_valid,
	output cmd_t             cmd_code,
	output logic [15:0]      cmd_w0,
	output logic [15:0]      cmd_w1,
	output logic [15:0]      cmd_w2,
	output logic [15:0]      cmd_w3
);
	logic [15:0] words[$];
	logic        got_ack;
	logic        got_err;
	int          last_n;

	// Select rests at the pulled-up level
	initial begin
		sel_pin = 1'b1;
		cmd_valid = 1'b0;
		cmd_code = cmd_none;
		{cmd_w0, cmd_w1, cmd_w2, cmd_w3} = '0;
	end

	// Only changed while reset is held, so the choice is seen at power-up
	task set_sel(input logic v);
		sel_pin <= v;
	endtask

	// Waits out boot and store first, up to 300 cycles; a longer wait loses the request
	task send(input cmd_t c, input logic [15:0] a, b, d, e);
		int i;
		words = {};
		got_ack = 1'b0;
		got_err = 1'b0;
		last_n = 0;
		i = 0;
		do begin
			@(posedge mclk);
			i++;
		end while (ready_ff !== 1'b1 && i < 300);
		cmd_valid <= 1'b1;
		cmd_code <= c;
		{cmd_w0, cmd_w1, cmd_w2, cmd_w3} <= {a, b, d, e};
		@(posedge mclk);
		cmd_valid <= 1'b0;
		cmd_code <= cmd_none;
		// Inverted data after the strobe, so stale words cannot pass
		{cmd_w0, cmd_w1, cmd_w2, cmd_w3} <= ~{a, b, d, e};
		for (i = 0; i < 9; i++) begin
			@(posedge mclk);
			if (ack_ff === 1'b1) got_ack = 1'b1;
			if (err_ff === 1'b1) got_err = 1'b1;
			if (rsp_valid_ff === 1'b1) words.push_back(rsp_word_ff);
			if (rsp_last_ff === 1'b1) last_n = words.size();
		end
	endtask
endmodule

// [bench/air_quality_module_cmd_ctrl_test.sv]
// Purpose: Self-checking bench for the air-quality command controller
// Assumes: Shortened store and sample counts
// Notes:   The bench stands in for storage, feeding persisted values back
`timescale 1ns/1ps
`include "aq_cmd_defines.svh"
module air_quality_module_cmd_ctrl_test
	import aq_cmd_pkg::*;
;
	localparam int SMP = 20;
	localparam logic [15:0] Z = 16'h0000;
	localparam logic [15:0] LO [4] = '{`TGT_MIN, `LRN_MIN, 16'h0000, `SDEV_MIN};
	localparam logic [15:0] HI [4] = '{`TGT_MAX, `LRN_MAX, `GATE_MAX, `SDEV_MAX};
	localparam logic [15:0] BL [4] = '{16'h0000, 16'h0049, 16'h02d1, 16'h0009};
	localparam logic [15:0] BH [4] = '{16'h00fa, 16'h0001, 16'h0000, 16'h01f4};
	logic        mclk, rst_b, sel_pin, cmd_valid, ready_ff, measuring_ff, uart_mode_ff, ack_ff, err_ff;
	logic        rsp_valid_ff, rsp_last_ff, sample_ff, nv_write_ff, algo_load_ff;
	cmd_t        cmd_code;
	logic [15:0] cmd_w0, cmd_w1, cmd_w2, cmd_w3, index_in, raw_gas_signal, hum_raw, temp_raw, nv_ofs;
	logic [15:0] rsp_word_ff, hum_comp_ff, temp_comp_ff, nv_ofs_out_ff;
	logic [63:0] algo_state_in, nv_tune, nv_tune_out_ff, algo_state_out_ff, algo_seen;
	int          mismatches, num_checks, cyc, nv_hits, algo_hits;

	aq_cmd_ctrl #(.STARTUP_CYCLES(4), .STORE_CYCLES(10), .RESTART_CYCLES(4), .SAMPLE_CYCLES(SMP)) dut (
		.mclk(mclk), .rst_b(rst_b), .sel_pin(sel_pin), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
		.cmd_w0(cmd_w0), .cmd_w1(cmd_w1), .cmd_w2(cmd_w2), .cmd_w3(cmd_w3), .index_in(index_in),
		.raw_gas_signal(raw_gas_signal), .hum_raw(hum_raw), .temp_raw(temp_raw), .algo_state_in(algo_state_in),
		.nv_ofs(nv_ofs), .nv_tune(nv_tune), .ready_ff(ready_ff), .measuring_ff(measuring_ff),
		.uart_mode_ff(uart_mode_ff), .ack_ff(ack_ff), .err_ff(err_ff), .rsp_valid_ff(rsp_valid_ff),
		.rsp_word_ff(rsp_word_ff), .rsp_last_ff(rsp_last_ff), .sample_ff(sample_ff), .hum_comp_ff(hum_comp_ff),
		.temp_comp_ff(temp_comp_ff), .nv_write_ff(nv_write_ff), .nv_ofs_out_ff(nv_ofs_out_ff),
		.nv_tune_out_ff(nv_tune_out_ff), .algo_load_ff(algo_load_ff), .algo_state_out_ff(algo_state_out_ff));

	aq_host_model host (
		.mclk(mclk), .ready_ff(ready_ff), .ack_ff(ack_ff), .err_ff(err_ff), .rsp_valid_ff(rsp_valid_ff),
		.rsp_word_ff(rsp_word_ff), .rsp_last_ff(rsp_last_ff), .sel_pin(sel_pin), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .cmd_w0(cmd_w0), .cmd_w1(cmd_w1), .cmd_w2(cmd_w2), .cmd_w3(cmd_w3));

	// 100 MHz clock
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// Storage stand-in and pulse monitors; values persist across resets
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (nv_write_ff === 1'b1) begin
			nv_hits <= nv_hits + 1;
			nv_ofs <= nv_ofs_out_ff;
			nv_tune <= nv_tune_out_ff;
		end
		if (algo_load_ff === 1'b1) begin
			algo_hits <= algo_hits + 1;
			algo_seen <= algo_state_out_ff;
		end
	end

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task report_and_stop;
		$display("checks=%0d mismatches=%0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	function automatic logic [15:0] clampv(input logic [15:0] v, lo, hi);
		return (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	// Reset held four cycles, then boot must end quickly
	task do_reset(input logic s);
		int i;
		@(posedge mclk);
		rst_b <= 1'b0;
		host.set_sel(s);
		repeat (4) @(posedge mclk);
		rst_b <= 1'b1;
		for (i = 0; i < 20 && ready_ff !== 1'b1; i++) @(posedge mclk);
		check(i <= 8, 1'b1);
		check(uart_mode_ff, s);
	endtask

	task expect_tune(input logic [15:0] e [4]);
		host.send(cmd_read_tuning, Z, Z, Z, Z);
		check(host.last_n, 4);
		check({host.words[0], host.words[1], host.words[2], host.words[3]}, {e[0], e[1], e[2], e[3]});
	endtask

	// Sample pulses are timed back to back, with no request between them
	task wait_sample(output int t);
		int i;
		for (i = 0; i < 60 && sample_ff !== 1'b1; i++) @(posedge mclk);
		t = cyc;
		@(posedge mclk);
	endtask

	initial begin
		logic [15:0] ofs, tw [4], ex [4];
		int          k, j, t0, t1;
		rst_b = 1'b0;
		{index_in, raw_gas_signal, hum_raw, temp_raw, algo_state_in, algo_seen} = '0;
		{mismatches, num_checks, cyc, nv_hits, algo_hits} = '0;
		void'($urandom(32'h25f6f65f));
		nv_ofs = 16'($urandom);
		for (j = 0; j < 4; j++) ex[j] = clampv(16'($urandom % 600), LO[j], HI[j]);
		nv_tune = {ex[3], ex[2], ex[1], ex[0]};
		do_reset(1'b1);
		expect_tune(ex);
		host.send(cmd_read_temp_offset, Z, Z, Z, Z);
		check(host.words[0], nv_ofs);
		$display("startup test done");
		// Both range edges, then a random set
		for (k = 0; k < 3; k++) begin
			for (j = 0; j < 4; j++) tw[j] = (k == 0) ? BL[j] : ((k == 1) ? BH[j] : 16'($urandom % 800));
			for (j = 0; j < 4; j++) ex[j] = clampv(tw[j], LO[j], HI[j]);
			host.send(cmd_write_tuning, tw[0], tw[1], tw[2], tw[3]);
			check(host.got_ack, 1'b1);
			expect_tune(ex);
		end
		$display("tuning test done");
		@(posedge mclk);
		{index_in, raw_gas_signal, hum_raw} <= 48'({$urandom, $urandom});
		temp_raw <= 16'h4000 + 16'($urandom % 4096);
		algo_state_in <= {$urandom, $urandom};
		ofs = 16'($urandom % 256);
		host.send(cmd_write_temp_offset, ofs, Z, Z, Z);
		check({host.got_ack, host.got_err}, 2'b10);
		host.send(cmd_begin_sampling, Z, Z, Z, Z);
		check(measuring_ff, 1'b1);
		wait_sample(t0);
		wait_sample(t1);
		check(t1 - t0, SMP);
		check(temp_comp_ff, temp_raw - ofs);
		host.send(cmd_read_outputs, Z, Z, Z, Z);
		check({host.words.size(), host.last_n}, {32'd3, 32'd3});
		check({host.words[0], host.words[2]}, {index_in, 16'(temp_raw - ofs)});
		host.send(cmd_read_outputs_with_raw, Z, Z, Z, Z);
		check(host.last_n, 6);
		check({host.words[3], host.words[4], host.words[5]}, {raw_gas_signal, hum_raw, temp_raw});
		check(measuring_ff, 1'b1);
		$display("measure test done");
		host.send(cmd_write_temp_offset, ~ofs, Z, Z, Z);
		check(host.got_err, 1'b1);
		host.send(cmd_write_algo_state, ofs, ofs, ofs, ofs);
		check(host.got_err, 1'b1);
		host.send(cmd_read_temp_offset, Z, Z, Z, Z);
		check(host.words[0], ofs);
		host.send(cmd_persist_settings, Z, Z, Z, Z);
		check(host.got_ack, 1'b1);
		check(measuring_ff, 1'b1);
		expect_tune(ex);
		check(nv_hits, 1);
		check({nv_ofs, nv_tune[47:0]}, {ofs, ex[2], ex[1], ex[0]});
		check(nv_tune[63:48], ex[3]);
		$display("persist test done");
		// State may only be written in idle, so measuring is stopped first
		host.send(cmd_end_sampling, Z, Z, Z, Z);
		for (j = 0; j < 4; j++) tw[j] = 16'($urandom);
		host.send(cmd_write_algo_state, tw[0], tw[1], tw[2], tw[3]);
		check(host.got_ack, 1'b1);
		host.send(cmd_begin_sampling, Z, Z, Z, Z);
		check(algo_seen, {tw[3], tw[2], tw[1], tw[0]});
		host.send(cmd_end_sampling, Z, Z, Z, Z);
		check(measuring_ff, 1'b0);
		host.send(cmd_begin_sampling, Z, Z, Z, Z);
		host.send(cmd_end_sampling, Z, Z, Z, Z);
		check(algo_hits, 1);
		$display("state test done");
		host.send(cmd_write_temp_offset, ~ofs, Z, Z, Z);
		host.send(cmd_write_tuning, 16'h0002, 16'h0002, 16'h0002, 16'h0020);
		host.send(cmd_write_algo_state, tw[0], tw[1], tw[2], tw[3]);
		host.send(cmd_soft_restart, Z, Z, Z, Z);
		check(host.got_ack, 1'b1);
		expect_tune(ex);
		host.send(cmd_read_temp_offset, Z, Z, Z, Z);
		check(host.words[0], ofs);
		host.send(cmd_begin_sampling, Z, Z, Z, Z);
		check(algo_hits, 1);
		do_reset(1'b0);
		check(measuring_ff, 1'b0);
		expect_tune(ex);
		$display("restart test done");
		report_and_stop();
	end

	// About 400 cycles of tests; 3000 cycles means a hang
	initial begin
		#30000;
		mismatches++;
		report_and_stop();
	end
endmodule
